//--- rtl/csc_pkg.sv
// Constants for the card status change interrupt block
package csc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  CSC_IDX_INTGEN   = 8'h03;
  localparam logic [7:0]  CSC_IDX_FLAGS    = 8'h04;
  localparam logic [7:0]  CSC_IDX_CONFIG   = 8'h05;
  localparam logic [7:0]  CSC_IDX_WIN      = 8'h06;
  localparam logic [7:0]  CSC_IDX_GLOBAL   = 8'h1E;
  localparam logic [7:0]  CSC_IDX_EVT_ST   = 8'h20;
  localparam logic [7:0]  CSC_IDX_EVT_EN   = 8'h21;
  localparam logic [7:0]  CSC_IDX_EVT_CLR  = 8'h22;
  localparam int          CSC_ADDR_W       = 10;
  localparam int          CSC_SYS_ADDR_W   = 26;
  // Flag bit positions
  localparam int          CSC_B_CD         = 3;
  localparam int          CSC_B_RDY        = 2;
  localparam int          CSC_B_BWARN      = 1;
  localparam int          CSC_B_BDEAD      = 0;
  // Interrupt and general control fields
  localparam int          CSC_B_RING_SEL   = 7;
  localparam int          CSC_B_CARD_RST   = 6;
  localparam int          CSC_B_CARD_IO    = 5;
  // Global control: explicit write-back mode bit
  localparam int          CSC_B_EXPLICIT   = 0;
  // Reset values and write masks
  localparam logic [7:0]  CSC_RST_INTGEN   = 8'h03;
  localparam logic [7:0]  CSC_RST_CONFIG   = 8'h00;
  localparam logic [7:0]  CSC_RST_WIN      = 8'h00;
  localparam logic [7:0]  CSC_RST_GLOBAL   = 8'h00;
  localparam logic [1:0]  CSC_RST_CD_PREV  = 2'h3;
  localparam logic [7:0]  CSC_WIN_MASK     = 8'hDF;
  localparam logic [7:0]  CSC_INTGEN_MASK  = 8'hEF;
endpackage

//--- rtl/csc_irq.sv
// Card status change flags, steered interrupt, window enables and APB registers
`timescale 1ns/100ps
`default_nettype none
module csc_irq
  import csc_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [CSC_ADDR_W-1:0]     paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [1:0]                card_present_lines_n,
  input  wire logic                      card_ready_busy_line,
  input  wire logic                      battery_warning_in,
  input  wire logic                      battery_dead_in,
  input  wire logic                      card_status_change_line_n,
  input  wire logic                      io_access,
  input  wire logic [1:0]                io_window_hit,
  input  wire logic                      mem_access,
  input  wire logic [4:0]                mem_window_hit,
  input  wire logic [CSC_SYS_ADDR_W-1:0] sys_addr,
  output logic      [15:0]               sys_irq,
  output logic                           irq,
  output logic                           ring_indicate_out,
  output logic                           card_enable,
  output logic      [CSC_SYS_ADDR_W-1:0] card_addr,
  output logic                           card_reset
);

  typedef struct packed {
    logic [3:0]                flags;
    logic [1:0]                cd_prev;
    logic                      rdy_prev;
    logic                      bw_prev;
    logic                      bd_prev;
    logic [7:0]                config_r;
    logic [7:0]                intgen;
    logic [7:0]                glob;
    logic [7:0]                win;
    logic [3:0]                evt_st;
    logic [3:0]                evt_en;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [15:0]               sys_irq;
    logic                      irq;
    logic                      ring;
    logic                      card_en;
    logic [CSC_SYS_ADDR_W-1:0] card_addr;
    logic                      card_rst;
  } csc_state_t;

  csc_state_t s_q;
  csc_state_t s_d;

  // Steer code to one-hot system IRQ line; reserved codes route nowhere
  function automatic logic [15:0] csc_steer(input logic [3:0] code);
    logic [15:0] hot;
    hot = 16'h0000;
    case (code)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF: begin
        hot[code] = 1'b1;
      end
      default: begin
        hot = 16'h0000;
      end
    endcase
    return hot;
  endfunction

  logic       io_card;
  logic       ring_sel;
  logic       explicit_wb;
  logic [3:0] src_en;
  logic [3:0] visible;
  logic [3:0] set_ev;
  logic [3:0] clr;
  logic [7:0] idx;
  logic       acc_start;
  logic       acc_done;
  logic       wr_done;
  logic       rd_done;
  logic       mapped;
  logic [7:0] rd_val;
  logic       sc_active;

  always_comb begin
    io_card     = s_q.intgen[CSC_B_CARD_IO];
    ring_sel    = s_q.intgen[CSC_B_RING_SEL];
    explicit_wb = s_q.glob[CSC_B_EXPLICIT];
    src_en      = s_q.config_r[3:0];
    visible     = s_q.flags & src_en;
    idx         = paddr[CSC_ADDR_W-1:2];
    acc_start   = psel & penable & ~s_q.pready;
    acc_done    = psel & penable & s_q.pready;
    wr_done     = acc_done & pwrite;
    rd_done     = acc_done & ~pwrite;
    // Events: edge of each card-side signal except the I/O status line, which is a level
    set_ev[CSC_B_CD]    = |(card_present_lines_n ^ s_q.cd_prev);
    set_ev[CSC_B_RDY]   = ~io_card & card_ready_busy_line & ~s_q.rdy_prev;
    set_ev[CSC_B_BWARN] = ~io_card & battery_warning_in & ~s_q.bw_prev;
    // I/O status line is a level source and is ignored under ring select
    set_ev[CSC_B_BDEAD] = io_card ? (~ring_sel & ~card_status_change_line_n)
                                  : (battery_dead_in & ~s_q.bd_prev);
    mapped = 1'b1;
    rd_val = 8'h00;
    if (idx == CSC_IDX_FLAGS) begin
      // Upper nibble is reserved and reads zero
      rd_val = {4'h0, visible};
    end else if (idx == CSC_IDX_CONFIG) begin
      rd_val = s_q.config_r;
    end else if (idx == CSC_IDX_WIN) begin
      rd_val = s_q.win;
    end else if (idx == CSC_IDX_INTGEN) begin
      rd_val = s_q.intgen;
    end else if (idx == CSC_IDX_GLOBAL) begin
      rd_val = s_q.glob;
    end else if (idx == CSC_IDX_EVT_ST) begin
      rd_val = {4'h0, s_q.evt_st};
    end else if (idx == CSC_IDX_EVT_EN) begin
      rd_val = {4'h0, s_q.evt_en};
    end else if (idx == CSC_IDX_EVT_CLR) begin
      rd_val = 8'h00;
    end else begin
      mapped = 1'b0;
    end
    // Acknowledge; bits cleared are those the master saw, so a late event survives
    clr = 4'h0;
    if (wr_done && idx == CSC_IDX_FLAGS && explicit_wb) begin
      clr = pwdata[3:0] & visible;
    end else if (rd_done && idx == CSC_IDX_FLAGS && !explicit_wb) begin
      clr = s_q.prdata[3:0];
    end
    // Same clear in both modes: interrupt lasts until enabled flags are zero
    sc_active = |(s_q.flags & src_en);

    s_d          = s_q;
    s_d.cd_prev  = card_present_lines_n;
    s_d.rdy_prev = card_ready_busy_line;
    s_d.bw_prev  = battery_warning_in;
    s_d.bd_prev  = battery_dead_in;
    // Set beats clear in the same cycle
    s_d.flags = (s_q.flags & ~clr) | set_ev;
    if (io_card) begin
      // I/O cards never report ready or battery warning
      s_d.flags[CSC_B_RDY]   = 1'b0;
      s_d.flags[CSC_B_BWARN] = 1'b0;
    end
    s_d.evt_st = s_q.evt_st | set_ev;
    // APB: one wait state, registered answer
    s_d.pready = acc_start;
    if (acc_start) begin
      s_d.prdata  = {24'h00_0000, rd_val};
      s_d.pslverr = ~mapped;
    end else if (acc_done) begin
      s_d.prdata  = 32'h0000_0000;
      s_d.pslverr = 1'b0;
    end
    if (wr_done && mapped) begin
      if (idx == CSC_IDX_CONFIG) begin
        s_d.config_r = pwdata[7:0];
      end else if (idx == CSC_IDX_WIN) begin
        s_d.win = pwdata[7:0] & CSC_WIN_MASK;
      end else if (idx == CSC_IDX_INTGEN) begin
        s_d.intgen = pwdata[7:0] & CSC_INTGEN_MASK;
      end else if (idx == CSC_IDX_GLOBAL) begin
        s_d.glob = {7'h00, pwdata[CSC_B_EXPLICIT]};
      end else if (idx == CSC_IDX_EVT_EN) begin
        s_d.evt_en = pwdata[3:0];
      end else if (idx == CSC_IDX_EVT_CLR) begin
        s_d.evt_st = (s_q.evt_st & ~pwdata[3:0]) | set_ev;
      end
    end
    // Registered so the card reset pin follows the control write without a gate in the path
    s_d.card_rst = ~s_d.intgen[CSC_B_CARD_RST];
    s_d.irq     = |(s_q.evt_st & s_q.evt_en);
    s_d.sys_irq = sc_active ? csc_steer(s_q.config_r[7:4]) : 16'h0000;
    s_d.ring    = io_card & ring_sel & ~card_status_change_line_n;
    // Window start/stop are assumed stable once a window is switched on
    s_d.card_en = (io_access & |(io_window_hit & s_q.win[7:6]))
                | (mem_access & |(mem_window_hit & s_q.win[4:0]));
    s_d.card_addr = sys_addr;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q           <= '0;
      s_q.cd_prev   <= CSC_RST_CD_PREV;
      s_q.config_r  <= CSC_RST_CONFIG;
      s_q.intgen    <= CSC_RST_INTGEN;
      s_q.glob      <= CSC_RST_GLOBAL;
      s_q.win       <= CSC_RST_WIN;
      s_q.card_rst  <= ~CSC_RST_INTGEN[CSC_B_CARD_RST];
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata            = s_q.prdata;
  assign pready            = s_q.pready;
  assign pslverr           = s_q.pslverr;
  assign sys_irq           = s_q.sys_irq;
  assign irq               = s_q.irq;
  assign ring_indicate_out = s_q.ring;
  assign card_enable       = s_q.card_en;
  assign card_addr         = s_q.card_addr;
  // Bit clear holds the card in reset
  assign card_reset        = s_q.card_rst;

endmodule
`default_nettype wire

//--- tb/csc_sva.sv
// Port-level assertions for the status change interrupt block
`timescale 1ns/100ps
`default_nettype none
module csc_sva
  import csc_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire logic                  pwrite,
  input wire logic [CSC_ADDR_W-1:0] paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  card_status_change_line_n,
  input wire logic                  io_access,
  input wire logic                  mem_access,
  input wire logic [1:0]            io_window_hit,
  input wire logic [4:0]            mem_window_hit,
  input wire logic [15:0]           sys_irq,
  input wire logic                  ring_indicate_out,
  input wire logic                  card_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  steer_one_hot_a: assert property ($onehot0(sys_irq)) else $error("steer not one-hot");
  steer_reserved_a: assert property ((sys_irq & 16'h2147) == 16'h0000) else $error("reserved irq");
  status_upper_zero_a: assert property (pready && !pwrite && paddr[9:2] == CSC_IDX_FLAGS
    |-> prdata[7:4] == 4'h0) else $error("status upper bits set");
  read_word_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper word");
  ring_needs_line_a: assert property (ring_indicate_out |-> $past(card_status_change_line_n) == 1'b0)
    else $error("ring without line low");
  idle_no_enable_a: assert property (!io_access && !mem_access |=> !card_enable) else $error("enable idle");
  miss_no_enable_a: assert property (io_window_hit == 2'h0 && mem_window_hit == 5'h00 |=> !card_enable)
    else $error("enable outside windows");
  irq_fall_ack_a: assert property ($fell(|sys_irq) |-> $past(pready) || $past(pready, 2))
    else $error("irq dropped without access");
endmodule
bind csc_irq csc_sva u_csc_sva (
  .core_clk(core_clk), .reset(reset), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .card_status_change_line_n(card_status_change_line_n), .io_access(io_access), .mem_access(mem_access),
  .io_window_hit(io_window_hit), .mem_window_hit(mem_window_hit), .sys_irq(sys_irq),
  .ring_indicate_out(ring_indicate_out), .card_enable(card_enable));
`default_nettype wire

//--- tb/csc_card.sv
// Behavioural card in the socket, driving its status lines on request
`timescale 1ns/100ps
`default_nettype none
module csc_card (
  input  wire logic       core_clk,
  input  wire logic [4:0] req,
  output logic      [1:0] cd_n,
  output logic            rdy,
  output logic            bw,
  output logic            bd,
  output logic            st_n
);
  always_ff @(posedge core_clk) begin
    cd_n <= {2{~req[4]}};
    rdy  <= req[3];
    bw   <= req[2];
    bd   <= req[1];
    // Released line floats to its pull-up level
    st_n <= ~req[0];
  end
endmodule
`default_nettype wire

//--- tb/csc_irq_tb_top.sv
// Self-checking bench for the status change interrupt block
`timescale 1ns/100ps
`default_nettype none
module csc_irq_tb_top import csc_pkg::*;;
  localparam logic [9:0] A_GEN = {CSC_IDX_INTGEN, 2'b00}, A_FLG = {CSC_IDX_FLAGS, 2'b00},
    A_CFG = {CSC_IDX_CONFIG, 2'b00}, A_WIN = {CSC_IDX_WIN, 2'b00}, A_GLB = {CSC_IDX_GLOBAL, 2'b00},
    A_EST = {CSC_IDX_EVT_ST, 2'b00}, A_EEN = {CSC_IDX_EVT_EN, 2'b00}, A_ECL = {CSC_IDX_EVT_CLR, 2'b00};
  logic        core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, io_access = 0, mem_access = 0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, irq, ring, rdy, bw, bd, st_n;
  logic [15:0] sys_irq;
  logic        card_en, card_rst;
  logic [25:0] card_addr;
  logic [26:0] w_exp;
  logic [7:0]  win_e = '0;
  logic [25:0] sys_addr = '0;
  logic [1:0]  io_hit = '0, cd_n;
  logic [4:0]  mem_hit = '0, req = '0;
  logic [7:0]  rw;
  logic [32:0] q[$];
  int          failures = 0, n_tests = 0;
  csc_irq u_csc_irq (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_present_lines_n(cd_n),
    .card_ready_busy_line(rdy), .battery_warning_in(bw), .battery_dead_in(bd), .card_status_change_line_n(st_n),
    .io_access(io_access), .io_window_hit(io_hit), .mem_access(mem_access), .mem_window_hit(mem_hit),
    .sys_addr(sys_addr), .sys_irq(sys_irq), .irq(irq), .ring_indicate_out(ring), .card_enable(card_en),
    .card_addr(card_addr), .card_reset(card_rst));
  csc_card u_csc_card (.core_clk(core_clk), .req(req), .cd_n(cd_n), .rdy(rdy), .bw(bw), .bd(bd), .st_n(st_n));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (!reset) {io_access, mem_access, io_hit, mem_hit, sys_addr} <= 35'({$urandom, $urandom});
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Reads note their expected word; the monitor below compares at pready
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [7:0] e = 0,
                     input logic err = 0);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1;
    if (!w) q.push_back({err, 24'h00_0000, e});
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    if (w && a == A_WIN) win_e <= d & CSC_WIN_MASK;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  always @(posedge core_clk)
    if (pready === 1'b1 && !pwrite) chk({pslverr, prdata}, q.pop_front());
  // Card enable and address appear one cycle after the random access qualifiers
  always @(posedge core_clk) begin
    if (!reset) chk({6'h00, card_en, card_addr}, {6'h00, w_exp});
    w_exp <= {(io_access & |(io_hit & win_e[7:6])) | (mem_access & |(mem_hit & win_e[4:0])), sys_addr};
  end
  function automatic logic [15:0] steer(input logic [3:0] c);
    case (c)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF: steer = 16'h0001 << c;
      default: steer = 16'h0000;
    endcase
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h6099_3d1b));
    repeat (20) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    chk(33'(card_rst), 33'h1);
    apb(0, A_CFG, 0, CSC_RST_CONFIG);
    apb(0, A_WIN, 0, CSC_RST_WIN);
    apb(0, A_FLG, 0, 8'h00);
    apb(0, 10'h3FC, 0, 8'h00, 1'b1);
    apb(1, A_GEN, 8'h43);
    chk(33'(card_rst), 33'h0);
    rw = 8'($urandom);
    apb(1, A_WIN, rw);
    apb(0, A_WIN, 0, rw & CSC_WIN_MASK);
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      apb(1, A_CFG, {c[3:0], 4'h8});
      req[4] <= ~req[4];
      repeat (4) @(posedge core_clk);
      chk({17'h0_0000, sys_irq}, {17'h0_0000, steer(c[3:0])});
      apb(0, A_FLG, 0, 8'h08);
      repeat (2) @(posedge core_clk);
      chk({17'h0_0000, sys_irq}, 33'h0_0000_0000);
    end
    $display("test steering done");
    apb(1, A_CFG, 8'h30);
    apb(1, A_ECL, 8'h0F);
    apb(1, A_EEN, 8'h08);
    req[4] <= ~req[4];
    repeat (4) @(posedge core_clk);
    chk(33'(irq), 33'h1);
    apb(0, A_FLG, 0, 8'h00);
    chk({17'h0_0000, sys_irq}, 33'h0_0000_0000);
    apb(0, A_EST, 0, 8'h08);
    apb(1, A_EEN, 8'h00);
    apb(1, A_ECL, 8'h08);
    apb(1, A_EEN, 8'h08);
    repeat (2) @(posedge core_clk);
    chk(33'(irq), 33'h0);
    apb(1, A_CFG, 8'h38);
    apb(0, A_FLG, 0, 8'h08);
    $display("test masking done");
    apb(1, A_GLB, 8'h01);
    apb(1, A_CFG, 8'h3F);
    req[3:1] <= 3'b111;
    repeat (4) @(posedge core_clk);
    apb(0, A_FLG, 0, 8'h07);
    apb(1, A_FLG, 8'h04);
    apb(0, A_FLG, 0, 8'h03);
    chk({17'h0_0000, sys_irq}, 33'h0_0000_0008);
    apb(1, A_FLG, 8'h03);
    repeat (2) @(posedge core_clk);
    chk({17'h0_0000, sys_irq}, 33'h0_0000_0000);
    $display("test explicit done");
    apb(1, A_GLB, 8'h00);
    req[3:1] <= 3'b000;
    apb(1, A_GEN, 8'h63);
    req[3:2] <= 2'b11;
    req[0] <= 1;
    repeat (4) @(posedge core_clk);
    req[0] <= 0;
    repeat (3) @(posedge core_clk);
    apb(0, A_FLG, 0, 8'h01);
    apb(0, A_FLG, 0, 8'h00);
    apb(1, A_GEN, 8'hE3);
    req[0] <= 1;
    repeat (4) @(posedge core_clk);
    chk(33'(ring), 33'h1);
    apb(0, A_FLG, 0, 8'h00);
    req[0] <= 0;
    $display("test io card done");
    summarize();
  end
  // Whole run takes well under a thousand cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
